//--- core/tlec_sys_stage.sv
// Purpose: System stage: peripheral mask, status, wake, forwarding
// Assumes: Peripheral requests are levels on the core clock
// Notes: Drops a busy level for one cycle on acknowledge
`timescale 1ns/100ps
`default_nettype none
module tlec_sys_stage
    import tlec_pkg::*;
(
    input wire logic clock,               // Core clock
    input wire logic arst_n,              // Async reset, active low
    input wire logic [SRC_N-1:0] src_irq, // Peripheral requests
    tlec_if.sys bus                       // Link to core stage
);
    logic [31:0] pmask_reg;
    logic [31:0] wake_reg;
    logic [31:0] stat_reg;
    logic [31:0] pend_d_reg;
    logic [31:0] gap_reg;
    logic [31:0] level_reg;
    logic wake_out_reg;
    logic [31:0] routed;
    logic [31:0] ack;

    // Peripheral mask and wake enable writes
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pmask_reg <= RST_PERI_MASK;
            wake_reg <= RST_PERI_WAKE;
        end else if (bus.acc_wr) begin
            if (bus.acc_idx == IDX_PERI_MASK) begin
                pmask_reg <= bus.acc_wdata;
            end
            if (bus.acc_idx == IDX_PERI_WAKE) begin
                wake_reg <= bus.acc_wdata;
            end
        end
    end

    // Status follows the raw requests
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            stat_reg <= 32'h0000_0000;
        end else begin
            stat_reg <= src_irq;
        end
    end

    // OR of unmasked sources onto each level
    always_comb begin
        routed = 32'h0000_0000;
        for (int s = 0; s < SRC_N; s++) begin
            if (src_irq[s] && pmask_reg[s]) begin
                routed[tlec_default_level(s)] = 1'b1;
            end
        end
    end

    // Pending rising edge is the acknowledge
    assign ack = bus.pending & ~pend_d_reg;

    // Forwarded levels with a one-cycle gap after acknowledge
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pend_d_reg <= 32'h0000_0000;
            gap_reg <= 32'h0000_0000;
            level_reg <= 32'h0000_0000;
        end else begin
            pend_d_reg <= bus.pending;
            gap_reg <= ack;
            level_reg <= routed & ~gap_reg;
        end
    end

    // Wake request while core is idle
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wake_out_reg <= 1'b0;
        end else begin
            wake_out_reg <= bus.core_idle && |(src_irq & wake_reg);
        end
    end

    assign bus.gp_level = level_reg;
    assign bus.wake_req = wake_out_reg;

    // Read data of own registers
    always_comb begin
        case (bus.acc_idx)
            IDX_PERI_MASK: bus.sys_rdata = pmask_reg;
            IDX_PERI_STAT: bus.sys_rdata = stat_reg;
            IDX_PERI_WAKE: bus.sys_rdata = wake_reg;
            default: bus.sys_rdata = 32'h0000_0000;
        endcase
    end
endmodule : tlec_sys_stage
`default_nettype wire

//--- core/tlec_top.sv
// Purpose: Two-level event controller, core stage and access port
// Assumes: Core accept/return pulses come from the pipeline
// Notes: Lower bit index means higher priority
// Functional notes
// - Latch, mask, pending: three 32-bit registers
// - Latch set on capture, cleared on accept
// - Latch writes only where mask bit clear
// - Mask bit gates servicing of latched event
// - Mask accessible only in supervisor mode
// - Global enable/disable instructions gate GP events
// - Pending records every active or nested event
// - Pending hardware-only, supervisor read, writes ignored
// - Peripheral mask, status, wake: 32-bit each
// - Peripheral mask bit forwards or blocks source
// - Status bit shows source asserting now
// - Wake-enabled source wakes idle core
// - Shared level tolerates overlapping pulses
// - Pending rise acts as acknowledge
// - Rising edge detection takes two cycles
// - Pending sets, latch clears, next edge queued
// - Pending no sooner than three cycles
// - Sources 29, 30, 31 share level thirteen
// - All registers supervisor-only, refused to peripherals
`timescale 1ns/100ps
`default_nettype none
module tlec_top
    import tlec_pkg::*;
(
    input wire logic clock,                 // Core clock, 25 MHz
    input wire logic arst_n,                // Async reset, active low
    input wire logic [SRC_N-1:0] src_irq,   // Peripheral requests
    input wire logic [GP_LO-1:0] sys_evt,   // Core-internal events 0..6
    input wire logic core_idle,             // Core is idled
    input wire logic gie_set,               // Global enable instruction
    input wire logic gie_clr,               // Global disable instruction
    input wire logic core_accept,           // Pipeline takes offered event
    input wire logic core_return,           // Return from innermost event
    input wire logic acc_req,               // Register access request
    input wire logic acc_wr,                // 1 write, 0 read
    input wire logic [2:0] acc_idx,         // Register index
    input wire logic [31:0] acc_wdata,      // Write data
    input wire logic acc_super,             // Requester in supervisor mode
    input wire logic acc_periph,            // Requester is a peripheral
    output logic acc_ack,                   // Access done, one cycle
    output logic acc_err,                   // Access refused
    output logic [31:0] acc_rdata,          // Read data
    output logic evt_offer,                 // Event offered to pipeline
    output logic [LVL_W-1:0] evt_idx,       // Offered event number
    output logic [31:0] evt_pending,        // Pending bits
    output logic wake_req                   // Wake request to core
);
    import tlec_pkg::*;

    tlec_if link ();

    logic [31:0] latch_reg;
    logic [31:0] mask_reg;
    logic [31:0] pend_reg;
    logic gie_reg;
    logic [31:0] s1_reg;
    logic [31:0] s2_reg;
    logic offer_reg;
    logic [LVL_W-1:0] idx_reg;
    logic ack_reg;
    logic err_reg;
    logic [31:0] rdata_reg;
    logic wake_reg;
    logic [31:0] raw_evt;
    logic [31:0] edge_evt;
    logic [31:0] enabled;
    logic [31:0] cand;
    logic allowed;
    logic mapped;
    logic wr_ok;
    logic take;
    logic [31:0] take_bit;
    logic [31:0] ret_bit;

    // Lowest set bit as a one-hot vector
    function automatic logic [31:0] tlec_lowest(input logic [31:0] v);
        logic [31:0] r;
        r = v & (~v + 32'h0000_0001);
        return r;
    endfunction : tlec_lowest

    // Index of lowest set bit
    function automatic logic [LVL_W-1:0] tlec_index(input logic [31:0] v);
        logic [LVL_W-1:0] r;
        r = '0;
        for (int i = 31; i >= 0; i--) begin
            if (v[i]) begin
                r = LVL_W'(i);
            end
        end
        return r;
    endfunction : tlec_index

    // System stage
    tlec_sys_stage u_sys (
        .clock(clock),
        .arst_n(arst_n),
        .src_irq(src_irq),
        .bus(link.sys)
    );

    // Access checks
    assign mapped = (acc_idx <= IDX_PERI_WAKE);
    assign allowed = acc_super && !acc_periph && mapped;
    assign wr_ok = acc_req && acc_wr && allowed;

    assign link.pending = pend_reg;
    assign link.core_idle = core_idle;
    assign link.acc_wr = wr_ok;
    assign link.acc_idx = acc_idx;
    assign link.acc_wdata = acc_wdata;

    // Raw core event inputs
    assign raw_evt = {16'h0000, link.gp_level[GP_HI:GP_LO], sys_evt};

    // Two-stage rising edge detector
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s1_reg <= 32'h0000_0000;
            s2_reg <= 32'h0000_0000;
        end else begin
            s1_reg <= raw_evt;
            s2_reg <= s1_reg;
        end
    end
    assign edge_evt = s1_reg & ~s2_reg & IMPL_BITS;

    // Global enable for general-purpose events
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            gie_reg <= 1'b0;
        end else if (gie_clr) begin
            gie_reg <= 1'b0;
        end else if (gie_set) begin
            gie_reg <= 1'b1;
        end
    end

    // Candidates: latched, unmasked, enabled, above current nesting
    assign enabled = latch_reg & mask_reg & (gie_reg ? 32'hffff_ffff : ~GP_BITS);
    assign cand = enabled & ((tlec_lowest(pend_reg) - 32'h0000_0001) | (pend_reg == 32'h0 ? 32'hffff_ffff : 32'h0));
    assign take = offer_reg && core_accept && cand[idx_reg];
    assign take_bit = take ? (32'h0000_0001 << idx_reg) : 32'h0000_0000;
    assign ret_bit = core_return ? tlec_lowest(pend_reg) : 32'h0000_0000;

    // Offer to the pipeline, one cycle behind the latch
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            offer_reg <= 1'b0;
            idx_reg <= '0;
        end else begin
            offer_reg <= |cand && !take;
            idx_reg <= tlec_index(cand);
        end
    end

    // Latch: edges set, accept clears, masked bits writable
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            latch_reg <= RST_CORE_LATCH;
        end else begin
            if (wr_ok && acc_idx == IDX_CORE_LATCH) begin
                latch_reg <= (((latch_reg & mask_reg) | (acc_wdata & ~mask_reg)) & ~take_bit
                              | edge_evt) & IMPL_BITS;
            end else begin
                latch_reg <= (latch_reg & ~take_bit) | edge_evt;
            end
        end
    end

    // Mask register
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mask_reg <= RST_CORE_MASK;
        end else if (wr_ok && acc_idx == IDX_CORE_MASK) begin
            mask_reg <= acc_wdata & IMPL_BITS;
        end
    end

    // Pending: set on accept, innermost cleared on return
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pend_reg <= RST_CORE_PEND;
        end else begin
            pend_reg <= (pend_reg & ~ret_bit) | take_bit;
        end
    end

    // Access answer one cycle after request
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= acc_req;
            err_reg <= acc_req && !allowed;
            if (acc_req && !acc_wr && allowed) begin
                case (acc_idx)
                    IDX_CORE_LATCH: rdata_reg <= latch_reg;
                    IDX_CORE_MASK: rdata_reg <= mask_reg;
                    IDX_CORE_PEND: rdata_reg <= pend_reg;
                    default: rdata_reg <= link.sys_rdata;
                endcase
            end else if (acc_req) begin
                rdata_reg <= 32'h0000_0000;
            end
        end
    end

    // Wake request retimed for the port
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wake_reg <= 1'b0;
        end else begin
            wake_reg <= link.wake_req;
        end
    end

    assign acc_ack = ack_reg;
    assign acc_err = err_reg;
    assign acc_rdata = rdata_reg;
    assign evt_offer = offer_reg;
    assign evt_idx = idx_reg;
    assign evt_pending = pend_reg;
    assign wake_req = wake_reg;
endmodule : tlec_top
`default_nettype wire

//--- inc/tlec_if.sv
// Purpose: Carrier between core stage and system stage
// Assumes: Same clock on both sides
// Notes: Access strobes are already privilege-checked
`timescale 1ns/100ps
`default_nettype none
interface tlec_if;
    logic [31:0] gp_level;   // Forwarded level per core event bit
    logic [31:0] pending;    // Core pending bits
    logic core_idle;         // Core idled
    logic wake_req;          // Wake request from system stage
    logic acc_wr;            // Permitted write strobe
    logic [2:0] acc_idx;     // Register index
    logic [31:0] acc_wdata;  // Write data
    logic [31:0] sys_rdata;  // Read data of system registers
    modport sys (output gp_level, output wake_req, output sys_rdata,
                 input pending, input core_idle, input acc_wr, input acc_idx, input acc_wdata);
    modport core (input gp_level, input wake_req, input sys_rdata,
                  output pending, output core_idle, output acc_wr, output acc_idx, output acc_wdata);
endinterface : tlec_if
`default_nettype wire

//--- inc/tlec_pkg.sv
// Purpose: Shared constants for the two-level event controller
// Assumes: One core clock; register indices are word indices
// Notes: Event priority falls with rising bit index
package tlec_pkg;
    localparam int EVT_W = 32;
    localparam int SRC_N = 32;
    localparam int GP_LO = 7;
    localparam int GP_HI = 15;
    localparam int LVL_W = 5;
    // Register indices on the access port
    localparam logic [2:0] IDX_CORE_LATCH = 3'h0;
    localparam logic [2:0] IDX_CORE_MASK = 3'h1;
    localparam logic [2:0] IDX_CORE_PEND = 3'h2;
    localparam logic [2:0] IDX_PERI_MASK = 3'h3;
    localparam logic [2:0] IDX_PERI_STAT = 3'h4;
    localparam logic [2:0] IDX_PERI_WAKE = 3'h5;
    // Reset values
    localparam logic [31:0] RST_CORE_LATCH = 32'h0000_0000;
    localparam logic [31:0] RST_CORE_MASK = 32'h0000_0000;
    localparam logic [31:0] RST_CORE_PEND = 32'h0000_0000;
    localparam logic [31:0] RST_PERI_MASK = 32'h0000_0000;
    localparam logic [31:0] RST_PERI_WAKE = 32'h0000_0000;
    // Levels implemented (bits above GP_HI read zero)
    localparam logic [31:0] IMPL_BITS = 32'h0000_ffff;
    // General-purpose bits, gated by the global enable
    localparam logic [31:0] GP_BITS = 32'h0000_ff80;
    // Level shared by the stream and watchdog/port sources
    localparam logic [LVL_W-1:0] SHARED_LVL = 5'h0d;
    localparam int SHARED_FIRST = 29;

    // Default routing of a peripheral source to a core level
    function automatic logic [LVL_W-1:0] tlec_default_level(input int src);
        logic [LVL_W-1:0] lvl;
        lvl = 5'(GP_LO + (src % 6));
        if (src >= SHARED_FIRST) begin
            lvl = SHARED_LVL;
        end
        return lvl;
    endfunction : tlec_default_level
endpackage : tlec_pkg

//--- test/tlec_core_model.sv
// Purpose: Pipeline model taking and returning offered events
// Assumes: One nesting level only
// Notes: dly sets accept delay, hold the service time
`timescale 1ns/100ps
`default_nettype none
module tlec_core_model (
    input wire logic clock, // Core clock
    input wire logic arst_n, // Reset, active low
    input wire logic evt_offer, // Offer from controller
    input wire logic [3:0] dly, // Offer cycles before take
    input wire logic [7:0] hold, // Service cycles
    output logic core_accept, // Take pulse
    output logic core_return // Return pulse
);
    int w;
    int b;
    // Take an offer after dly cycles, return after hold cycles
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            w <= 0;
            b <= 0;
            core_accept <= 1'b0;
            core_return <= 1'b0;
        end else begin
            core_accept <= 1'b0;
            core_return <= 1'b0;
            if (b > 0) begin
                b <= b - 1;
                core_return <= (b == 1);
            end else if (evt_offer && !core_accept) begin
                w <= w + 1;
                if (w >= int'(dly)) begin
                    core_accept <= 1'b1;
                    w <= 0;
                    b <= int'(hold);
                end
            end
        end
    end
endmodule : tlec_core_model
`default_nettype wire

//--- test/tlec_props.sv
// Purpose: Port checker for the event controller top
// Assumes: One clock, reset asynchronous active low
// Notes: Bound onto every tlec_top instance
`timescale 1ns/100ps
`default_nettype none
module tlec_props (
    input wire logic clock, // Core clock
    input wire logic arst_n, // Reset, active low
    input wire logic core_idle, // Core idled
    input wire logic core_accept, // Take pulse
    input wire logic core_return, // Return pulse
    input wire logic acc_req, // Access request
    input wire logic acc_wr, // Write
    input wire logic [2:0] acc_idx, // Index
    input wire logic acc_super, // Supervisor
    input wire logic acc_periph, // Peripheral requester
    input wire logic acc_ack, // Ack
    input wire logic acc_err, // Refused
    input wire logic [31:0] acc_rdata, // Read data
    input wire logic evt_offer, // Offer
    input wire logic [tlec_pkg::LVL_W-1:0] evt_idx, // Offered event
    input wire logic [31:0] evt_pending, // Pending bits
    input wire logic wake_req // Wake request
);
    import tlec_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    // Accepted offer, and a core awake in the first of two cycles
    sequence s_take;
        core_accept && evt_offer && !core_return;
    endsequence
    sequence s_busy;
        !core_idle ##1 1'b1;
    endsequence
    ack_after_req_a: assert property (acc_req |=> acc_ack)
        else $error("access not acknowledged");
    refused_access_a: assert property (acc_req && (!acc_super || acc_periph || acc_idx > 3'h5)
        |=> acc_err && acc_rdata == 32'h0) else $error("access not refused");
    pend_write_ign_a: assert property (acc_req && acc_wr && acc_idx == IDX_CORE_PEND && !core_accept
        && !core_return |=> evt_pending == $past(evt_pending)) else $error("pending written");
    pend_cause_a: assert property ((evt_pending & ~$past(evt_pending)) != 32'h0
        |-> $past(core_accept && evt_offer)) else $error("pending set without accept");
    take_sets_pend_a: assert property (s_take |=> evt_pending[$past(evt_idx)] && !evt_offer)
        else $error("accept did not set pending");
    ret_clear_low_a: assert property (core_return && !core_accept
        |=> evt_pending == ($past(evt_pending) & ($past(evt_pending) - 32'h1))) else $error("bad return");
    wake_idle_only_a: assert property (s_busy |=> !wake_req)
        else $error("wake while core busy");
    high_bits_zero_a: assert property (evt_pending[31:16] == 16'h0 && !(evt_offer && evt_idx[4]))
        else $error("unimplemented event active");
endmodule : tlec_props
bind tlec_top tlec_props u_props (.clock, .arst_n, .core_idle, .core_accept, .core_return, .acc_req, .acc_wr,
    .acc_idx, .acc_super, .acc_periph, .acc_ack, .acc_err, .acc_rdata, .evt_offer, .evt_idx, .evt_pending,
    .wake_req);
`default_nettype wire

//--- test/tlec_tb_top.sv
// Purpose: Self-checking bench for the event controller
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Register table rows first, event cases after
`timescale 1ns/100ps
`default_nettype none
module tlec_tb_top;
    import tlec_pkg::*;
    typedef struct packed {logic wr; logic [2:0] idx; logic sup; logic per; logic err; logic pad;
        logic [31:0] dat;} tlec_row_s;
    logic clock = 1'b0, arst_n = 1'b0, core_idle = 1'b0, gie_set = 1'b0, gie_clr = 1'b0;
    logic acc_req = 1'b0, acc_wr = 1'b0, acc_super = 1'b0, acc_periph = 1'b0;
    logic [2:0] acc_idx = 3'h0;
    logic [31:0] acc_wdata = 32'h0, src_irq = 32'h0;
    logic [6:0] sys_evt = 7'h0;
    logic [3:0] dly = 4'h0;
    logic [7:0] hold = 8'h1e;
    logic core_accept, core_return, acc_ack, acc_err, evt_offer, wake_req;
    logic [31:0] acc_rdata, evt_pending;
    logic [LVL_W-1:0] evt_idx;
    int n_errors = 0, n_compared = 0, n_acc = 0, cyc = 0, n;
    tlec_row_s r;
    tlec_row_s rows[19] = '{40'h08_0000_0000, 40'h18_0000_0000, 40'h28_0000_0000, 40'h38_0000_0000,
        40'h48_0000_0000, 40'h58_0000_0000, 40'h6a_0000_0000, 40'h98_0000_2800, 40'h92_0000_ffff,
        40'h18_0000_2800, 40'h1e_0000_0000, 40'ha8_0000_ffff, 40'h28_0000_0000, 40'h88_0000_6001,
        40'h08_0000_4001, 40'h88_0000_0000, 40'hb8_e000_0000, 40'hd8_8000_0000, 40'h7a_0000_0000};
    tlec_top dut (.clock, .arst_n, .src_irq, .sys_evt, .core_idle, .gie_set, .gie_clr, .core_accept,
        .core_return, .acc_req, .acc_wr, .acc_idx, .acc_wdata, .acc_super, .acc_periph, .acc_ack,
        .acc_err, .acc_rdata, .evt_offer, .evt_idx, .evt_pending, .wake_req);
    tlec_core_model u_core (.clock, .arst_n, .evt_offer, .dly, .hold, .core_accept, .core_return);
    // Clock, accept count and hang limit
    always #20 clock = ~clock;
    always @(posedge clock) begin
        n_acc = n_acc + int'(core_accept && evt_offer);
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask : tick
    task automatic acc(input logic w, input logic [2:0] i, input logic [31:0] d, input logic s, input logic p);
        tick(1);
        acc_req = 1'b1;
        acc_wr = w;
        acc_idx = i;
        acc_wdata = d;
        acc_super = s;
        acc_periph = p;
        tick(1);
        acc_req = 1'b0;
    endtask : acc
    task automatic gie(input logic on);
        tick(1);
        gie_set = on;
        gie_clr = !on;
        tick(1);
        gie_set = 1'b0;
        gie_clr = 1'b0;
    endtask : gie
    task automatic wait_pend(input int b);
        n = 0;
        while (evt_pending[b] !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
    endtask : wait_pend
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim
    // Main sequence
    initial begin
        tick(12);
        arst_n = 1'b1;
        foreach (rows[i]) begin
            r = rows[i];
            acc(r.wr, r.idx, r.dat, r.sup, r.per);
            chk({31'h0, acc_ack}, 32'h1);
            chk({31'h0, acc_err}, {31'h0, r.err});
            chk(acc_rdata, (r.wr || r.err) ? 32'h0 : r.dat);
        end
        $display("test registers done");
        gie(1'b1);
        n_acc = 0;
        src_irq[29] = 1'b1;
        wait_pend(13);
        chk(32'(n), 32'h6);
        acc(1'b0, IDX_PERI_STAT, 32'h0, 1'b1, 1'b0);
        chk(acc_rdata, 32'h2000_0000);
        tick(4);
        acc(1'b0, IDX_CORE_LATCH, 32'h0, 1'b1, 1'b0);
        chk(acc_rdata, 32'h2000);
        src_irq[29] = 1'b0;
        tick(90);
        chk(32'(n_acc), 32'h2);
        chk(evt_pending, 32'h0);
        $display("test shared level done");
        src_irq[28] = 1'b1;
        tick(10);
        chk({31'h0, evt_offer}, 32'h0);
        acc(1'b0, IDX_PERI_STAT, 32'h0, 1'b1, 1'b0);
        chk(acc_rdata, 32'h1000_0000);
        acc(1'b0, IDX_CORE_LATCH, 32'h0, 1'b1, 1'b0);
        chk(acc_rdata, 32'h0);
        src_irq[28] = 1'b0;
        $display("test peripheral mask done");
        gie(1'b0);
        src_irq[30] = 1'b1;
        tick(10);
        chk({31'h0, evt_offer}, 32'h0);
        acc(1'b0, IDX_CORE_LATCH, 32'h0, 1'b1, 1'b0);
        chk(acc_rdata, 32'h2000);
        src_irq[30] = 1'b0;
        gie(1'b1);
        tick(1);
        chk({31'h0, evt_offer}, 32'h1);
        chk({27'h0, evt_idx}, 32'hd);
        wait_pend(13);
        chk(32'(n < 10), 32'h1);
        tick(70);
        $display("test global enable done");
        core_idle = 1'b1;
        src_irq[31] = 1'b1;
        tick(2);
        chk({31'h0, wake_req}, 32'h1);
        core_idle = 1'b0;
        src_irq[31] = 1'b0;
        tick(70);
        $display("test wake done");
        src_irq[29] = 1'b1;
        wait_pend(13);
        src_irq[29] = 1'b0;
        arst_n = 1'b0;
        #1;
        chk(evt_pending, 32'h0);
        chk({31'h0, evt_offer}, 32'h0);
        tick(12);
        arst_n = 1'b1;
        acc(1'b0, IDX_CORE_MASK, 32'h0, 1'b1, 1'b0);
        chk(acc_rdata, 32'h0);
        $display("test reset done");
        end_sim();
    end
endmodule : tlec_tb_top
`default_nettype wire
